// *** verif/acoc_spi_master.sv ***
`timescale 1ns/1ps
// ==========
// serial master stand-in
module acoc_spi_master #(
    parameter int GAP_NS = 2000
) (
    // clock
    input wire logic clock,
    // toward the device
    output logic cs_n,
    output logic acc_req_valid,
    output logic acc_req_axis,
    output logic offset_cancel_select_n
);
    logic sclk;
    initial begin
        cs_n = 1'h1;
        sclk = 1'h0;
        acc_req_valid = 1'h0;
        acc_req_axis = 1'h0;
        offset_cancel_select_n = 1'h1;
    end
    // link clock toggles only inside a frame, odd phase to the core clock
    task frame;
        #137 cs_n = 1'h0;
        repeat (32) #200 sclk = ~sclk;
        #100 cs_n = 1'h1;
    endtask
    task access(input logic ax, input logic sel);
        frame();
        @(negedge clock);
        acc_req_valid = 1'h1;
        acc_req_axis = ax;
        offset_cancel_select_n = sel;
        @(negedge clock);
        acc_req_valid = 1'h0;
        acc_req_axis = ~ax;
        offset_cancel_select_n = ~sel;
        #(GAP_NS);
        frame();
    endtask
endmodule // acoc_spi_master

// *** verif/acoc_top_asserts.sv ***
`timescale 1ns/1ps
// ==========
// port checker
module acoc_top_asserts #(
    parameter int DW = 10,
    parameter int BLANK_CYC = 100
) (
    // clock, reset, requests
    input wire logic clock,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic acc_req_valid,
    input wire logic acc_req_axis,
    // control
    input wire logic selftest_active,
    input wire logic offset_monitor_enable,
    input wire logic signed [DW-1:0] offset_limit_positive,
    input wire logic signed [DW-1:0] offset_limit_negative,
    // outputs
    input wire logic resp_axis_q,
    input wire logic resp_strobe_q,
    input wire logic x_over_range_q,
    input wire logic y_over_range_q,
    input wire logic signed [DW-1:0] x_offset_correction_value_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic pend_q;
    logic ax_q;
    int unsigned blk_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            pend_q <= 1'h0;
            ax_q <= 1'h0;
            blk_q <= 32'h0;
        end else begin
            if (acc_req_valid) begin
                pend_q <= 1'h1;
                ax_q <= acc_req_axis;
            end else if (resp_strobe_q) begin
                pend_q <= 1'h0;
            end
            if (blk_q < BLANK_CYC) begin
                blk_q <= blk_q + 32'h1;
            end
        end
    end
    sequence s_st_held;
        selftest_active [*3];
    endsequence
    sequence s_mon_idle;
        (!offset_monitor_enable && !selftest_active) [*3];
    endsequence
    sequence s_req_fall;
        $fell(cs_n) && pend_q;
    endsequence
    a_strobe_one: assert property (resp_strobe_q |=> !resp_strobe_q)
        else $error("response strobe too long");
    a_resp_after_fall: assert property (s_req_fall |-> ##[2:6] resp_strobe_q)
        else $error("no response after frame start");
    a_no_stray_resp: assert property (resp_strobe_q |-> pend_q)
        else $error("response without request");
    a_resp_axis: assert property (resp_strobe_q |-> resp_axis_q == ax_q)
        else $error("response axis wrong");
    a_reset_clears: assert property (@(posedge clock) disable iff (1'h0) rst |=>
        !resp_strobe_q && !x_over_range_q && x_offset_correction_value_q == '0)
        else $error("outputs not cleared by reset");
    a_corr_step: assert property (
        x_offset_correction_value_q == $past(x_offset_correction_value_q)
        || x_offset_correction_value_q - $past(x_offset_correction_value_q) == 1
        || $past(x_offset_correction_value_q) - x_offset_correction_value_q == 1)
        else $error("correction jumped");
    a_st_freeze: assert property (s_st_held |->
        $stable(x_offset_correction_value_q) && $stable(x_over_range_q))
        else $error("offset moved in self-test");
    a_mon_blank: assert property (blk_q < BLANK_CYC - 2 |->
        !x_over_range_q && !y_over_range_q)
        else $error("monitor active while blanked");
    a_mon_off: assert property (s_mon_idle |-> !x_over_range_q && !y_over_range_q)
        else $error("monitor active while disabled");
    a_over_cause: assert property ($rose(x_over_range_q) |->
        x_offset_correction_value_q > offset_limit_positive
        || x_offset_correction_value_q < offset_limit_negative)
        else $error("over-range without cause");
endmodule // acoc_top_asserts
bind acoc_top acoc_top_asserts #(.DW(DW), .BLANK_CYC(BLANK_CYC)) i_acoc_top_asserts (
    .clock(clock), .rst(rst), .cs_n(cs_n), .acc_req_valid(acc_req_valid),
    .acc_req_axis(acc_req_axis), .selftest_active(selftest_active),
    .offset_monitor_enable(offset_monitor_enable),
    .offset_limit_positive(offset_limit_positive), .offset_limit_negative(offset_limit_negative),
    .resp_axis_q(resp_axis_q), .resp_strobe_q(resp_strobe_q), .x_over_range_q(x_over_range_q),
    .y_over_range_q(y_over_range_q), .x_offset_correction_value_q(x_offset_correction_value_q)
);

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
// ==========
// bench top
module tb_top;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic ss = 1'h0, err = 1'h0, st = 1'h0, mon = 1'h1;
    logic [2:0] cfg = 3'h3;
    logic [1:0] xw = 2'h0, yw = 2'h0, xp = 2'h0, yp = 2'h0;
    logic signed [7:0] tp = 8'h04, tn = 8'hFC;
    logic signed [9:0] xs = 10'h000, ys = 10'h000, xa = 10'h005, ya = 10'h3FD;
    logic cs_n, arv, ara, ocs, rax, rs, apx, apy, xo, yo, a_early, a_late;
    logic [9:0] rd, got_d;
    logic signed [9:0] xc, yc;
    int sc = 0, since = 100, got_n = 0, cyc = 0, fail_count = 0, compares = 0;
    acoc_top #(.DS_CYC(4), .BLANK_CYC(100), .PS_UNIT(10)) i_acoc_top (
        .clock(clock), .rst(rst), .sample_strobe(ss), .x_sample(xs), .y_sample(ys),
        .cs_n(cs_n), .acc_req_valid(arv), .acc_req_axis(ara), .offset_cancel_select_n(ocs),
        .error_event(err), .selftest_active(st), .offset_monitor_enable(mon),
        .device_config_reg(cfg), .offset_limit_positive(10'h003),
        .offset_limit_negative(10'h3FD), .x_window_size_field(xw), .y_window_size_field(yw),
        .x_pulse_stretch_setting(xp), .y_pulse_stretch_setting(yp),
        .x_arming_threshold_pos(tp), .x_arming_threshold_neg(tn),
        .y_arming_threshold_pos(tp), .y_arming_threshold_neg(tn),
        .resp_data_q(rd), .resp_axis_q(rax), .resp_strobe_q(rs), .arm_x_pin_q(apx),
        .arm_y_pin_q(apy), .x_over_range_q(xo), .y_over_range_q(yo),
        .x_offset_correction_value_q(xc), .y_offset_correction_value_q(yc)
    );
    acoc_spi_master i_acoc_spi_master (
        .clock(clock), .cs_n(cs_n), .acc_req_valid(arv), .acc_req_axis(ara),
        .offset_cancel_select_n(ocs)
    );
    always #25 clock = ~clock;
    // one sample every 8 us, as the dsp delivers them
    always @(negedge clock) begin
        sc <= (sc == 159) ? 0 : sc + 1;
        ss <= (sc == 0);
        xs <= xa;
        ys <= ya;
    end
    // arm pin is looked at shortly after the response and after the stretch
    always @(posedge clock) begin
        since <= (rs === 1'h1) ? 0 : since + 1;
        if (rs === 1'h1) begin
            got_d <= rd;
            got_n <= got_n + 1;
        end
        if (since == 3) a_early <= apx;
        if (since == 45) a_late <= apx;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            $display("unexpected timeout: expected end seen cycle %0d", cyc);
            results();
        end
    end
    // ==========
    // shared tasks
    task automatic w(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk_v(input string n, input logic [9:0] e, input logic [9:0] s);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk_b(input string n, input logic e, input logic s);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s: expected %b seen %b", n, e, s);
        end
    endtask
    task automatic req(input logic ax, input logic sel, input logic [9:0] e);
        int n0;
        n0 = got_n;
        i_acoc_spi_master.access(ax, sel);
        chk_b("resp_strobe", 1'h1, got_n == n0 + 1);
        chk_v("resp_data", e, got_d);
    endtask
    // x correction is frozen at 7 here, so the cancelled value is v - 7
    task automatic hit(input logic [9:0] v, input logic e1, input logic e2);
        w(1);
        xa = v;
        w(350);
        req(1'h0, 1'h0, v - 10'h007);
        chk_b("arm_x_early", e1, a_early);
        chk_b("arm_x_late", e2, a_late);
        chk_b("arm_y_idle", cfg[2], apy);
    endtask
    // ==========
    // scenarios
    task t_offset;
        w(1500);
        chk_v("x_corr", 10'h005, xc);
        chk_v("y_corr", 10'h3FD, yc);
        chk_b("x_over", 1'h1, xo);
        chk_b("y_over", 1'h0, yo);
        req(1'h0, 1'h1, 10'h005);
        req(1'h0, 1'h0, 10'h000);
        req(1'h1, 1'h0, 10'h000);
        $display("done t_offset");
    endtask
    task t_selftest;
        w(1);
        st = 1'h1;
        xa = 10'h007;
        w(2);
        mon = 1'h0;
        w(300);
        chk_v("x_corr_frozen", 10'h005, xc);
        chk_b("x_over_frozen", 1'h1, xo);
        mon = 1'h1;
        st = 1'h0;
        w(1500);
        chk_v("x_corr_recovery", 10'h005, xc);
        w(1500);
        chk_v("x_corr_resumed", 10'h007, xc);
        chk_b("x_over_resumed", 1'h1, xo);
        mon = 1'h0;
        w(4);
        chk_b("x_over_disabled", 1'h0, xo);
        st = 1'h1;
        $display("done t_selftest");
    endtask
    task t_arm_ma;
        w(1);
        cfg = 3'h0;
        xp = 2'h3;
        hit(10'h01B, 1'h1, 1'h0);
        xw = 2'h1;
        xp = 2'h0;
        hit(10'h007, 1'h1, 1'h1);
        hit(10'h007, 1'h0, 1'h0);
        hit(10'h00D, 1'h0, 1'h0);
        $display("done t_arm_ma");
    endtask
    task t_arm_cnt;
        w(1);
        cfg = 3'h5;
        xp = 2'h3;
        hit(10'h007, 1'h1, 1'h1);
        hit(10'h01B, 1'h1, 1'h1);
        hit(10'h01B, 1'h0, 1'h1);
        hit(10'h007, 1'h1, 1'h1);
        hit(10'h01B, 1'h1, 1'h1);
        $display("done t_arm_cnt");
    endtask
    task t_error;
        w(1);
        cfg = 3'h0;
        xw = 2'h0;
        err = 1'h1;
        w(1);
        err = 1'h0;
        hit(10'h01B, 1'h0, 1'h0);
        $display("done t_error");
    endtask
    task results;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        w(16);
        rst = 1'h0;
        t_offset();
        t_selftest();
        t_arm_ma();
        t_arm_cnt();
        t_error();
        results();
    end
endmodule // tb_top

// *** verilog/acoc_arm.sv ***
`timescale 1ns/1ps
`include "acoc_params.svh"
module acoc_arm import acoc_pkg::*; #(
    parameter int DW = 10,
    parameter int PS_UNIT = `ACOC_PS_UNIT_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // sample taken at a response frame start
    input wire logic smp_pulse,
    input wire logic signed [DW-1:0] smp,
    // configuration
    input wire acoc_arm_mode_t mode,
    input wire logic [1:0] window_size_field,
    input wire logic [1:0] pulse_stretch_setting,
    input wire logic signed [7:0] thr_pos,
    input wire logic signed [7:0] thr_neg,
    // arming, active high
    output logic arm_q
);
    logic signed [DW-1:0] hist_q [0:7];
    logic [2:0] cnt_q;
    logic [23:0] ps_q;
    logic cond_q;
    logic signed [DW+2:0] wsum;
    // sum of the new sample and the last k-1 stored ones, k = 2^field;
    // kept in a process so the stored history is in its sensitivity
    always_comb begin
        wsum = (DW+3)'(smp);
        for (int i = 0; i < 7; i++)
            if (i < (1 << window_size_field) - 1)
                wsum = wsum + (DW+3)'(hist_q[i]);
    end
    wire signed [DW+2:0] avg = wsum >>> window_size_field;
    // thresholds are arguments so that a change to them re-evaluates the compare
    function automatic logic hit(input logic signed [DW+2:0] v, input logic signed [7:0] p,
                                 input logic signed [7:0] n);
        hit = (v >= (DW+3)'(p)) | (v <= (DW+3)'(n));
    endfunction
    wire smp_hit = hit((DW+3)'(smp), thr_pos, thr_neg);
    wire [2:0] cnt_d = smp_hit ? (cnt_q == 3'h7 ? cnt_q : cnt_q + 3'h1) : 3'h0;
    wire ma_c = hit(avg, thr_pos, thr_neg);
    wire cnt_c = cnt_d >= {1'b0, window_size_field} + 3'h1;
    wire cond = (mode == ARM_MA) ? ma_c : ((mode == ARM_CNT) ? cnt_c : smp_hit);
    wire stretch = (pulse_stretch_setting != 2'h0) & (mode != ARM_UNF);
    wire reload = smp_pulse & cond & (mode != ARM_OFF);
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 8; i++)
                hist_q[i] <= '0;
            cnt_q <= 3'h0;
            ps_q <= 24'h0;
            cond_q <= 1'b0;
        end else begin
            if (smp_pulse) begin
                hist_q[0] <= smp;
                for (int i = 1; i < 8; i++)
                    hist_q[i] <= hist_q[i-1];
                cnt_q <= cnt_d;
                cond_q <= cond & (mode != ARM_OFF);
            end
            if (reload)
                ps_q <= 24'(PS_UNIT) * {22'h0, pulse_stretch_setting};
            else if (ps_q != 24'h0)
                ps_q <= ps_q - 24'h1;
        end
    end
    // with stretch the output is the timer alone, so it only drops on expiry
    always_comb arm_q = stretch ? (ps_q != 24'h0) : cond_q;
endmodule // acoc_arm

// *** verilog/acoc_offset.sv ***
`timescale 1ns/1ps
`include "acoc_params.svh"
module acoc_offset import acoc_pkg::*; #(
    parameter int DW = 10,
    parameter int DS_CYC = `ACOC_DS_CYC,
    parameter int BLANK_CYC = `ACOC_MON_BLANK_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // cancelled data fed back
    input wire logic signed [DW-1:0] smp,
    // control
    input wire logic selftest_active,
    input wire logic offset_monitor_enable,
    input wire logic signed [DW-1:0] offset_limit_positive,
    input wire logic signed [DW-1:0] offset_limit_negative,
    // status
    output logic signed [DW-1:0] corr_q,
    output logic over_q
);
    logic [15:0] ds_q;
    logic [15:0] n_q;
    logic [10:0] pcnt_q;
    logic [11:0] rec_q;
    logic [31:0] blank_q;
    logic signed [27:0] sum_q;
    logic st_q;
    acoc_phase_t ph_q;
    function automatic logic [15:0] win_of(acoc_phase_t p);
        case (p)
            PH_START1: win_of = 16'(`ACOC_WIN_S1);
            PH_START2: win_of = 16'(`ACOC_WIN_S2);
            PH_START3: win_of = 16'(`ACOC_WIN_S3);
            default: win_of = 16'(`ACOC_WIN_NORM);
        endcase
    endfunction
    wire [15:0] win = win_of(ph_q);
    // selftest freezes accumulation, phases, correction and over flag, then a recovery hold
    wire susp = selftest_active | (rec_q != 12'h000);
    wire tick = (ds_q == 16'(DS_CYC - 1));
    wire take = tick & ~susp;
    wire signed [27:0] sum_n = sum_q + 28'(smp);
    wire signed [27:0] lim = 28'(win) * 28'(`ACOC_OC_THR);
    wire wdone = take & (n_q == win - 16'h0001);
    wire pdone = take & (pcnt_q == 11'(`ACOC_PHASE_SMP - 1)) & (ph_q != PH_NORMAL);
    // comparing the sum against win*thr avoids a divide by 3*2^k
    wire up = sum_n >= lim;
    wire dn = sum_n <= -lim;
    wire signed [DW-1:0] corr_d = up ? corr_q + 1'b1 : (dn ? corr_q - 1'b1 : corr_q);
    wire mon_ok = offset_monitor_enable & (blank_q == 32'h0);
    always_ff @(posedge clock) begin
        if (rst) begin
            ds_q <= 16'h0000;
            n_q <= 16'h0000;
            pcnt_q <= 11'h000;
            rec_q <= 12'h000;
            blank_q <= 32'(BLANK_CYC);
            sum_q <= 28'h0000000;
            st_q <= 1'b0;
            ph_q <= PH_START1;
            corr_q <= '0;
            over_q <= 1'b0;
        end else begin
            st_q <= selftest_active;
            ds_q <= tick ? 16'h0000 : ds_q + 16'h0001;
            if (blank_q != 32'h0)
                blank_q <= blank_q - 32'h1;
            if (st_q & ~selftest_active)
                rec_q <= 12'(`ACOC_ST_REC_CYC);
            else if (rec_q != 12'h000)
                rec_q <= rec_q - 12'h001;
            if (take)
                pcnt_q <= pcnt_q + 11'h001;
            if (pdone) begin
                ph_q <= acoc_phase_t'(ph_q + 2'h1);
                n_q <= 16'h0000;
                sum_q <= 28'h0000000;
            end else if (wdone) begin
                n_q <= 16'h0000;
                sum_q <= 28'h0000000;
                corr_q <= corr_d;
                if (mon_ok)
                    over_q <= (corr_d > offset_limit_positive) |
                              (corr_d < offset_limit_negative);
            end else if (take) begin
                n_q <= n_q + 16'h0001;
                sum_q <= sum_n;
            end
            if (~mon_ok & ~selftest_active)
                over_q <= 1'b0;
        end
    end
endmodule // acoc_offset

// *** verilog/acoc_params.svh ***
`ifndef ACOC_PARAMS_SVH
`define ACOC_PARAMS_SVH
// ==========================================
// clock
`define ACOC_CLK_MHZ 20
`define ACOC_CLK_NS 50
// ==========================================
// interpolation, sample time 8 us
`define ACOC_TS_NS 8000
`define ACOC_HALF_CYC ((`ACOC_TS_NS / 2) / `ACOC_CLK_NS)
// ==========================================
// offset canceller
`define ACOC_DS_US 256
`define ACOC_DS_CYC (`ACOC_DS_US * `ACOC_CLK_MHZ)
`define ACOC_PHASE_SMP 2048
`define ACOC_WIN_S1 48
`define ACOC_WIN_S2 384
`define ACOC_WIN_S3 3072
`define ACOC_WIN_NORM 24576
`define ACOC_OC_THR 1
`define ACOC_ST_REC_US 100
`define ACOC_ST_REC_CYC (`ACOC_ST_REC_US * `ACOC_CLK_MHZ)
// ==========================================
// offset monitor blanking after reset
`define ACOC_MON_BLANK_MS 2100
`define ACOC_MON_BLANK_CYC (`ACOC_MON_BLANK_MS * 1000 * `ACOC_CLK_MHZ)
// ==========================================
// arming
`define ACOC_PS_UNIT_MS 64
`define ACOC_PS_UNIT_CYC (`ACOC_PS_UNIT_MS * 1000 * `ACOC_CLK_MHZ)
`define ACOC_CFG_MODE_LSB 0
`define ACOC_CFG_POL_BIT 2
`define ACOC_CFG_RESET 3'h3
`endif

// *** verilog/acoc_pkg.sv ***
package acoc_pkg;
    // arming mode, low two bits of the arming/output configuration field
    typedef enum logic [1:0] {
        ARM_MA,
        ARM_CNT,
        ARM_UNF,
        ARM_OFF
    } acoc_arm_mode_t;
    // offset canceller startup phases
    typedef enum logic [1:0] {
        PH_START1,
        PH_START2,
        PH_START3,
        PH_NORMAL
    } acoc_phase_t;
endpackage

// *** verilog/acoc_top.sv ***
`timescale 1ns/1ps
`include "acoc_params.svh"
module acoc_top import acoc_pkg::*; #(
    parameter int DW = 10,
    parameter int DS_CYC = `ACOC_DS_CYC,
    parameter int BLANK_CYC = `ACOC_MON_BLANK_CYC,
    parameter int PS_UNIT = `ACOC_PS_UNIT_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // filtered samples from the dsp
    input wire logic sample_strobe,
    input wire logic signed [DW-1:0] x_sample,
    input wire logic signed [DW-1:0] y_sample,
    // chip select pin
    input wire logic cs_n,
    // decoded request from the serial front end
    input wire logic acc_req_valid,
    input wire logic acc_req_axis,
    input wire logic offset_cancel_select_n,
    input wire logic error_event,
    // configuration
    input wire logic selftest_active,
    input wire logic offset_monitor_enable,
    input wire logic [2:0] device_config_reg,
    input wire logic signed [DW-1:0] offset_limit_positive,
    input wire logic signed [DW-1:0] offset_limit_negative,
    input wire logic [1:0] x_window_size_field,
    input wire logic [1:0] y_window_size_field,
    input wire logic [1:0] x_pulse_stretch_setting,
    input wire logic [1:0] y_pulse_stretch_setting,
    input wire logic signed [7:0] x_arming_threshold_pos,
    input wire logic signed [7:0] x_arming_threshold_neg,
    input wire logic signed [7:0] y_arming_threshold_pos,
    input wire logic signed [7:0] y_arming_threshold_neg,
    // response data
    output logic [DW-1:0] resp_data_q,
    output logic resp_axis_q,
    output logic resp_strobe_q,
    // arming pins
    output logic arm_x_pin_q,
    output logic arm_y_pin_q,
    // offset status
    output logic x_over_range_q,
    output logic y_over_range_q,
    output logic signed [DW-1:0] x_offset_correction_value_q,
    output logic signed [DW-1:0] y_offset_correction_value_q
);
    // ==========================================
    // chip select synchroniser and edge
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end else begin
            cs_s1_q <= cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
        end
    end
    // seen two to three cycles after the pin edge, far inside one sample
    wire cs_fall = cs_s3_q & ~cs_s2_q;

    // ==========================================
    // per-axis views of the loose ports
    wire signed [DW-1:0] raw [0:1];
    assign raw[0] = x_sample;
    assign raw[1] = y_sample;
    wire [1:0] wsf [0:1];
    assign wsf[0] = x_window_size_field;
    assign wsf[1] = y_window_size_field;
    wire [1:0] psf [0:1];
    assign psf[0] = x_pulse_stretch_setting;
    assign psf[1] = y_pulse_stretch_setting;
    wire signed [7:0] tpos [0:1];
    assign tpos[0] = x_arming_threshold_pos;
    assign tpos[1] = y_arming_threshold_pos;
    wire signed [7:0] tneg [0:1];
    assign tneg[0] = x_arming_threshold_neg;
    assign tneg[1] = y_arming_threshold_neg;

    // ==========================================
    // saturate a widened value into the data width
    function automatic logic signed [DW-1:0] sat(input logic signed [DW:0] v);
        logic signed [DW:0] hi;
        logic signed [DW:0] lo;
        hi = (DW+1)'({1'b0, {(DW-1){1'b1}}});
        lo = -hi - (DW+1)'(1);
        if (v > hi)
            sat = DW'(hi);
        else if (v < lo)
            sat = DW'(lo);
        else
            sat = DW'(v);
    endfunction

    // ==========================================
    // half sample timer for the interpolator
    logic [15:0] half_q;
    logic half_run_q;
    wire half_hit = half_run_q & (half_q == 16'(`ACOC_HALF_CYC - 1));
    always_ff @(posedge clock) begin
        if (rst) begin
            half_q <= 16'h0000;
            half_run_q <= 1'b0;
        end else if (sample_strobe) begin
            half_q <= 16'h0000;
            half_run_q <= 1'b1;
        end else if (half_hit) begin
            half_run_q <= 1'b0;
        end else if (half_run_q) begin
            half_q <= half_q + 16'h0001;
        end
    end

    // ==========================================
    // configuration decode
    wire [1:0] mode_bits = device_config_reg[`ACOC_CFG_MODE_LSB +: 2];
    wire acoc_arm_mode_t arm_mode = acoc_arm_mode_t'(mode_bits);
    wire arm_low = device_config_reg[`ACOC_CFG_POL_BIT];

    // ==========================================
    // request held until the response frame opens
    logic pend_q;
    logic pend_axis_q;
    logic pend_ocn_q;
    logic lock_q;
    wire take = cs_fall & pend_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            pend_q <= 1'b0;
            pend_axis_q <= 1'b0;
            pend_ocn_q <= 1'b1;
            lock_q <= 1'b0;
        end else begin
            // a new request arriving with the edge belongs to the next frame
            if (acc_req_valid) begin
                pend_q <= 1'b1;
                pend_axis_q <= acc_req_axis;
                pend_ocn_q <= offset_cancel_select_n;
            end else if (take) begin
                pend_q <= 1'b0;
            end
            // sticky until reset: a fault must not re-arm
            if (error_event)
                lock_q <= 1'b1;
        end
    end

    // ==========================================
    // per-axis interpolation, cancellation and arming
    logic signed [DW-1:0] out_q [0:1];
    logic signed [DW-1:0] held_q [0:1];
    wire signed [DW-1:0] canc [0:1];
    wire signed [DW-1:0] corr [0:1];
    wire over [0:1];
    wire arm [0:1];
    genvar a;
    generate
        for (a = 0; a < 2; a++) begin : g_axis
            wire signed [DW:0] mid_sum = (DW+1)'(held_q[a]) + (DW+1)'(raw[a]);
            wire signed [DW-1:0] mid = DW'(mid_sum >>> 1);
            always_ff @(posedge clock) begin
                if (rst) begin
                    out_q[a] <= '0;
                    held_q[a] <= '0;
                end else if (sample_strobe) begin
                    out_q[a] <= mid;
                    held_q[a] <= raw[a];
                end else if (half_hit) begin
                    out_q[a] <= held_q[a];
                end
            end
            assign canc[a] = sat((DW+1)'(out_q[a]) - (DW+1)'(corr[a]));
            wire smp_go = take & (pend_axis_q == 1'(a)) & ~lock_q;
            // independent instances: no state is shared between axes
            acoc_offset #(
                .DW(DW),
                .DS_CYC(DS_CYC),
                .BLANK_CYC(BLANK_CYC)
            ) u_off (
                .clock(clock),
                .rst(rst),
                .smp(canc[a]),
                .selftest_active(selftest_active),
                .offset_monitor_enable(offset_monitor_enable),
                .offset_limit_positive(offset_limit_positive),
                .offset_limit_negative(offset_limit_negative),
                .corr_q(corr[a]),
                .over_q(over[a])
            );
            acoc_arm #(
                .DW(DW),
                .PS_UNIT(PS_UNIT)
            ) u_arm (
                .clock(clock),
                .rst(rst),
                .smp_pulse(smp_go),
                .smp(canc[a]),
                .mode(arm_mode),
                .window_size_field(wsf[a]),
                .pulse_stretch_setting(psf[a]),
                .thr_pos(tpos[a]),
                .thr_neg(tneg[a]),
                .arm_q(arm[a])
            );
        end
    endgenerate

    // ==========================================
    // response latch
    wire signed [DW-1:0] sel_raw = pend_axis_q ? out_q[1] : out_q[0];
    wire signed [DW-1:0] sel_canc = pend_axis_q ? canc[1] : canc[0];
    wire [DW-1:0] resp_d = pend_ocn_q ? sel_raw : sel_canc;
    always_ff @(posedge clock) begin
        if (rst) begin
            resp_data_q <= '0;
            resp_axis_q <= 1'b0;
            resp_strobe_q <= 1'b0;
        end else begin
            resp_strobe_q <= take;
            if (take) begin
                resp_data_q <= resp_d;
                resp_axis_q <= pend_axis_q;
            end
        end
    end

    // ==========================================
    // pins and status
    always_ff @(posedge clock) begin
        if (rst) begin
            arm_x_pin_q <= 1'b0;
            arm_y_pin_q <= 1'b0;
            x_over_range_q <= 1'b0;
            y_over_range_q <= 1'b0;
            x_offset_correction_value_q <= '0;
            y_offset_correction_value_q <= '0;
        end else begin
            arm_x_pin_q <= arm[0] ^ arm_low;
            arm_y_pin_q <= arm[1] ^ arm_low;
            x_over_range_q <= over[0];
            y_over_range_q <= over[1];
            x_offset_correction_value_q <= corr[0];
            y_offset_correction_value_q <= corr[1];
        end
    end
endmodule // acoc_top
